// >>> rtl/eeprom_ctrl_pkg.sv
// Constants for the serial EEPROM host controller.
// Assumes a 40 MHz core clock and a 128 x 8 three-wire EEPROM.
package eeprom_ctrl_pkg;
	// Register byte offsets
	localparam logic [7:0] CMD_OFS   = 8'h00;
	localparam logic [7:0] DATA_OFS  = 8'h04;
	localparam logic [7:0] GPIO_OFS  = 8'h08;
	localparam logic [7:0] MACLO_OFS = 8'h0C;
	localparam logic [7:0] MACHI_OFS = 8'h10;
	// Command register fields
	localparam int BUSY_BIT   = 31;
	localparam int CMD_LSB    = 28;
	localparam int TO_BIT     = 9;
	localparam int LOADED_BIT = 8;
	localparam int ADDR_LSB   = 0;
	// GPIO configuration fields
	localparam int EN_BIT      = 0;
	localparam int GPO_DAT_BIT = 1;
	localparam int GPO_CLK_BIT = 2;
	localparam int MON_BIT     = 3;
	localparam logic [3:0] GPIO_RST = 4'h1;
	// Command codes
	typedef enum logic [2:0] {
		CMD_READ   = 3'h0,
		CMD_LOCK   = 3'h1,
		CMD_UNLOCK = 3'h2,
		CMD_WRITE  = 3'h3,
		CMD_FILL   = 3'h4,
		CMD_ERASE  = 3'h5,
		CMD_WIPE   = 3'h6,
		CMD_RELOAD = 3'h7
	} cmd_e;
	// Serial opcodes and extended sub-codes
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] OP_EXT   = 2'h0;
	localparam logic [1:0] EX_UNLOCK = 2'h3;
	localparam logic [1:0] EX_LOCK   = 2'h0;
	localparam logic [1:0] EX_WIPE   = 2'h2;
	localparam logic [1:0] EX_FILL   = 2'h1;
	// Frame lengths, signature, MAC size
	localparam logic [4:0] LEN_SHORT = 5'h0A;
	localparam logic [4:0] LEN_LONG  = 5'h12;
	localparam logic [7:0] SIGNATURE = 8'hA5;
	localparam logic [2:0] MAC_LAST  = 3'h6;
	// Timing: half serial clock period in core cycles, timeout
	localparam logic [2:0] SK_HALF    = 3'h4;
	// Clock rises early in the bit so returning data clears the sampler before the fall
	localparam logic [2:0] SK_RISE    = 3'h1;
	// Core cycles the status poll waits for the sampler to settle
	localparam logic [2:0] POLL_SETTLE = 3'h7;
	localparam int         CLK_HZ     = 40000000;
	localparam int         TIMEOUT_MS = 30;
	localparam int         TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	// Controller states
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_START  = 6'h02,
		ST_SHIFT  = 6'h04,
		ST_GAP    = 6'h08,
		ST_POLL   = 6'h10,
		ST_FINISH = 6'h20
	} state_e;
endpackage

// >>> rtl/eeprom_ctrl.sv
// Serial EEPROM host controller with APB register access.
// Assumes an APB master on core_clk_in and a three-wire EEPROM on the pins.
//
// Notes on behaviour
// - Host commands wait for the MAC auto-load
// - Busy set starts command, cleared at end
// - Read byte ready when busy clears
// - Thirty millisecond no-response timeout sets flag
// - Disabled interface turns pins into outputs
// - Erase clears selected location
// - Erase-all clears whole array
// - Write-disable command blocks modifications
// - Write-enable command permits modifications
// - Read fetches addressed byte into data
// - Write stores data byte at location
// - Write-all stores data everywhere
// - Ten or eighteen serial clocks per command
// - Reload fails without signature byte
// - Loaded flag only on successful reload
// - Six bytes follow signature, low first
// - Array is 128 eight-bit locations
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module eeprom_ctrl #(
	parameter int unsigned TIMEOUT_CYCLES = eeprom_ctrl_pkg::TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        soft_reset_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// EEPROM pins
	output logic             chip_select_out,
	output logic             serial_clock_out,
	output logic             serial_data_out,
	output logic             serial_data_oe_out,
	input  wire logic        serial_data_in,
	// Monitor sources and MAC address
	input  wire logic [1:0]  mii_monitor_in,
	output logic      [47:0] mac_addr_out
);
	////////////////////////////////////////////////////////////
	typedef eeprom_ctrl_pkg::cmd_e   cmd_t;
	typedef eeprom_ctrl_pkg::state_e st_t;

	// Builds the left-aligned serial frame
	function automatic logic [17:0] frame_word(input cmd_t c, input logic [6:0] a, input logic [7:0] d);
		logic [17:0] w;
		w = 18'h00000;
		case (c)
			eeprom_ctrl_pkg::CMD_READ,
			eeprom_ctrl_pkg::CMD_RELOAD: w = {1'h1, eeprom_ctrl_pkg::OP_READ, a, 8'h00};
			eeprom_ctrl_pkg::CMD_WRITE:  w = {1'h1, eeprom_ctrl_pkg::OP_WRITE, a, d};
			eeprom_ctrl_pkg::CMD_ERASE:  w = {1'h1, eeprom_ctrl_pkg::OP_ERASE, a, 8'h00};
			eeprom_ctrl_pkg::CMD_UNLOCK: w = {1'h1, eeprom_ctrl_pkg::OP_EXT, eeprom_ctrl_pkg::EX_UNLOCK, 13'h0000};
			eeprom_ctrl_pkg::CMD_LOCK:   w = {1'h1, eeprom_ctrl_pkg::OP_EXT, eeprom_ctrl_pkg::EX_LOCK, 13'h0000};
			eeprom_ctrl_pkg::CMD_WIPE:   w = {1'h1, eeprom_ctrl_pkg::OP_EXT, eeprom_ctrl_pkg::EX_WIPE, 13'h0000};
			eeprom_ctrl_pkg::CMD_FILL:   w = {1'h1, eeprom_ctrl_pkg::OP_EXT, eeprom_ctrl_pkg::EX_FILL, 5'h00, d};
			default:                     w = 18'h00000;
		endcase
		return w;
	endfunction

	// Read, write and write-all carry a data byte
	function automatic logic is_long(input cmd_t c);
		return c == eeprom_ctrl_pkg::CMD_READ || c == eeprom_ctrl_pkg::CMD_RELOAD ||
			c == eeprom_ctrl_pkg::CMD_WRITE || c == eeprom_ctrl_pkg::CMD_FILL;
	endfunction

	// Commands that program the array and report ready on the data line
	function automatic logic needs_poll(input cmd_t c);
		return c == eeprom_ctrl_pkg::CMD_WRITE || c == eeprom_ctrl_pkg::CMD_FILL ||
			c == eeprom_ctrl_pkg::CMD_ERASE || c == eeprom_ctrl_pkg::CMD_WIPE;
	endfunction

	////////////////////////////////////////////////////////////
	st_t         state_q;
	logic        busy_q;
	logic        reload_q;
	logic        abandon_q;
	logic        to_flag_q;
	logic        loaded_q;
	cmd_t        cmd_q;
	logic [6:0]  addr_q;
	logic [7:0]  data_q;
	logic [3:0]  gpio_q;
	logic [2:0]  idx_q;
	logic [17:0] tx_q;
	logic [7:0]  rx_q;
	logic [4:0]  bits_q;
	logic [2:0]  div_q;
	logic        sk_q;
	logic        cs_q;
	logic        di_q;
	logic        oe_q;
	logic [20:0] tmo_q;
	logic        do_s1_q;
	logic        do_s2_q;
	logic        do_s3_q;
	logic        do_q;
	logic        acc;
	logic        wr_en;
	logic        host_start;
	logic        tmo_hit;
	logic        bit_end;
	cmd_t        cur_cmd;

	// Bus strobes
	assign acc        = psel_in && penable_in;
	assign wr_en      = acc && pwrite_in && pready_out;
	assign host_start = wr_en && paddr_in == eeprom_ctrl_pkg::CMD_OFS && pwdata_in[eeprom_ctrl_pkg::BUSY_BIT]
		&& !busy_q;
	assign cur_cmd    = reload_q ? eeprom_ctrl_pkg::CMD_RELOAD : cmd_q;
	assign tmo_hit    = tmo_q == 21'(TIMEOUT_CYCLES - 1);
	assign bit_end    = div_q == 3'(2 * eeprom_ctrl_pkg::SK_HALF - 1);

	////////////////////////////////////////////////////////////
	// Three-stage sampler for the returning data line
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			do_s1_q <= 1'h0;
			do_s2_q <= 1'h0;
			do_s3_q <= 1'h0;
			do_q    <= 1'h0;
		end else begin
			do_s1_q <= serial_data_in;
			do_s2_q <= do_s1_q;
			do_s3_q <= do_s2_q;
			if (do_s2_q == do_s3_q) begin
				do_q <= do_s3_q;
			end
		end
	end

	////////////////////////////////////////////////////////////
	// APB handshake: one wait state, registered read data
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out  <= 1'h0;
			pslverr_out <= 1'h0;
			prdata_out  <= 32'h00000000;
		end else begin
			pready_out  <= acc && !pready_out;
			pslverr_out <= 1'h0;
			if (acc && !pready_out) begin
				prdata_out <= 32'h00000000;
				case (paddr_in)
					eeprom_ctrl_pkg::CMD_OFS: begin
						prdata_out[eeprom_ctrl_pkg::BUSY_BIT]           <= busy_q;
						prdata_out[eeprom_ctrl_pkg::CMD_LSB +: 3]       <= cmd_q;
						prdata_out[eeprom_ctrl_pkg::TO_BIT]             <= to_flag_q;
						prdata_out[eeprom_ctrl_pkg::LOADED_BIT]         <= loaded_q;
						prdata_out[eeprom_ctrl_pkg::ADDR_LSB +: 7]      <= addr_q;
					end
					eeprom_ctrl_pkg::DATA_OFS:  prdata_out[7:0]  <= data_q;
					eeprom_ctrl_pkg::GPIO_OFS:  prdata_out[3:0]  <= gpio_q;
					eeprom_ctrl_pkg::MACLO_OFS: prdata_out       <= mac_addr_out[31:0];
					eeprom_ctrl_pkg::MACHI_OFS: prdata_out[15:0] <= mac_addr_out[47:32];
					default:                    pslverr_out      <= 1'h1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Interface configuration register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gpio_q <= eeprom_ctrl_pkg::GPIO_RST;
		end else if (wr_en && paddr_in == eeprom_ctrl_pkg::GPIO_OFS) begin
			gpio_q <= pwdata_in[3:0];
		end
	end

	// Command fields; writes ignored while busy
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_q  <= eeprom_ctrl_pkg::CMD_READ;
			addr_q <= 7'h00;
		end else if (host_start) begin
			cmd_q  <= cmd_t'(pwdata_in[eeprom_ctrl_pkg::CMD_LSB +: 3]);
			addr_q <= pwdata_in[eeprom_ctrl_pkg::ADDR_LSB +: 7];
		end
	end

	// Data register: host writes when idle, read result on finish
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_q <= 8'h00;
		end else if (state_q == eeprom_ctrl_pkg::ST_FINISH && !abandon_q && !reload_q
			&& cmd_q == eeprom_ctrl_pkg::CMD_READ) begin
			data_q <= rx_q;
		end else if (wr_en && !busy_q && paddr_in == eeprom_ctrl_pkg::DATA_OFS) begin
			data_q <= pwdata_in[7:0];
		end
	end

	// Timeout flag: hardware set wins over write-one clear
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			to_flag_q <= 1'h0;
		end else if (tmo_hit && state_q != eeprom_ctrl_pkg::ST_IDLE) begin
			to_flag_q <= 1'h1;
		end else if (wr_en && paddr_in == eeprom_ctrl_pkg::CMD_OFS && pwdata_in[eeprom_ctrl_pkg::TO_BIT]) begin
			to_flag_q <= 1'h0;
		end
	end

	// Timeout counter runs from the start of an operation
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tmo_q <= 21'h000000;
		end else if (state_q == eeprom_ctrl_pkg::ST_IDLE || state_q == eeprom_ctrl_pkg::ST_FINISH
			|| soft_reset_in) begin
			tmo_q <= 21'h000000;
		end else begin
			tmo_q <= tmo_q + 21'h000001;
		end
	end

	////////////////////////////////////////////////////////////
	// Sequencer: auto-load, host commands, reload, timeout
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q   <= eeprom_ctrl_pkg::ST_START;
			busy_q    <= 1'h1;
			reload_q  <= 1'h1;
			abandon_q <= 1'h0;
			loaded_q  <= 1'h0;
			idx_q     <= 3'h0;
			mac_addr_out <= 48'h000000000000;
		end else if (soft_reset_in) begin
			state_q   <= eeprom_ctrl_pkg::ST_START;
			busy_q    <= 1'h1;
			reload_q  <= 1'h1;
			abandon_q <= 1'h0;
			loaded_q  <= 1'h0;
			idx_q     <= 3'h0;
		end else if (tmo_hit && state_q != eeprom_ctrl_pkg::ST_IDLE && state_q != eeprom_ctrl_pkg::ST_FINISH) begin
			state_q   <= eeprom_ctrl_pkg::ST_FINISH;
			abandon_q <= 1'h1;
		end else begin
			case (state_q)
				eeprom_ctrl_pkg::ST_IDLE: begin
					if (host_start) begin
						state_q   <= eeprom_ctrl_pkg::ST_START;
						busy_q    <= 1'h1;
						abandon_q <= 1'h0;
						idx_q     <= 3'h0;
						reload_q  <= pwdata_in[eeprom_ctrl_pkg::CMD_LSB +: 3] == eeprom_ctrl_pkg::CMD_RELOAD;
						if (pwdata_in[eeprom_ctrl_pkg::CMD_LSB +: 3] == eeprom_ctrl_pkg::CMD_RELOAD) begin
							loaded_q <= 1'h0;
						end
					end
				end
				eeprom_ctrl_pkg::ST_START:  state_q <= eeprom_ctrl_pkg::ST_SHIFT;
				eeprom_ctrl_pkg::ST_SHIFT: begin
					if (bit_end && bits_q == 5'h01) begin
						state_q <= needs_poll(cur_cmd) ? eeprom_ctrl_pkg::ST_GAP : eeprom_ctrl_pkg::ST_FINISH;
					end
				end
				eeprom_ctrl_pkg::ST_GAP: begin
					if (bit_end) begin
						state_q <= eeprom_ctrl_pkg::ST_POLL;
					end
				end
				eeprom_ctrl_pkg::ST_POLL: begin
					if (do_q && div_q == eeprom_ctrl_pkg::POLL_SETTLE) begin // Stale level ignored
						state_q <= eeprom_ctrl_pkg::ST_FINISH;
					end
				end
				eeprom_ctrl_pkg::ST_FINISH: begin
					state_q <= eeprom_ctrl_pkg::ST_IDLE;
					busy_q  <= 1'h0;
					if (reload_q && !abandon_q) begin
						if (idx_q == 3'h0 && rx_q != eeprom_ctrl_pkg::SIGNATURE) begin
							reload_q <= 1'h0;
						end else if (idx_q == eeprom_ctrl_pkg::MAC_LAST) begin
							mac_addr_out[40 +: 8] <= rx_q;
							loaded_q <= 1'h1;
							reload_q <= 1'h0;
						end else begin
							if (idx_q != 3'h0) begin
								mac_addr_out[(6'(idx_q) - 6'h01) * 6'h08 +: 8] <= rx_q;
							end
							idx_q   <= idx_q + 3'h1;
							state_q <= eeprom_ctrl_pkg::ST_START;
							busy_q  <= 1'h1;
						end
					end else begin
						reload_q <= 1'h0;
					end
				end
				default: state_q <= eeprom_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// Serial engine: frame load, clock divider, shift and sample
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_q   <= 18'h00000;
			rx_q   <= 8'h00;
			bits_q <= 5'h00;
			div_q  <= 3'h0;
			sk_q   <= 1'h0;
			cs_q   <= 1'h0;
			di_q   <= 1'h0;
			oe_q   <= 1'h0;
		end else if (state_q == eeprom_ctrl_pkg::ST_START) begin
			tx_q   <= frame_word(cur_cmd, reload_q ? {4'h0, idx_q} : addr_q, data_q);
			bits_q <= is_long(cur_cmd) ? eeprom_ctrl_pkg::LEN_LONG : eeprom_ctrl_pkg::LEN_SHORT;
			div_q  <= 3'h0;
			cs_q   <= 1'h1;
			sk_q   <= 1'h0;
		end else if (state_q == eeprom_ctrl_pkg::ST_SHIFT) begin
			div_q <= div_q + 3'h1;
			if (div_q == 3'h0) begin
				di_q <= tx_q[17];
				oe_q <= !(is_long(cur_cmd) && !needs_poll(cur_cmd) && bits_q <= 5'h08);
			end
			if (div_q == eeprom_ctrl_pkg::SK_RISE) begin
				sk_q <= 1'h1;
			end
			if (bit_end) begin
				sk_q   <= 1'h0;
				rx_q   <= {rx_q[6:0], do_q};
				tx_q   <= {tx_q[16:0], 1'h0};
				bits_q <= bits_q - 5'h01;
				if (bits_q == 5'h01) begin
					cs_q <= 1'h0;
					oe_q <= 1'h0;
				end
			end
		end else if (state_q == eeprom_ctrl_pkg::ST_GAP) begin
			div_q <= div_q + 3'h1;
			if (bit_end) begin
				cs_q <= 1'h1;
			end
		end else if (state_q == eeprom_ctrl_pkg::ST_POLL) begin
			// Select held for the ready status; count until the sampler has settled
			if (div_q != eeprom_ctrl_pkg::POLL_SETTLE) begin
				div_q <= div_q + 3'h1;
			end
		end else begin
			cs_q <= 1'h0;
			sk_q <= 1'h0;
			oe_q <= 1'h0;
			div_q <= 3'h0;
		end
	end

	////////////////////////////////////////////////////////////
	// Pin outputs; disabled interface drives static or monitor levels
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chip_select_out    <= 1'h0;
			serial_clock_out   <= 1'h0;
			serial_data_out    <= 1'h0;
			serial_data_oe_out <= 1'h0;
		end else if (gpio_q[eeprom_ctrl_pkg::EN_BIT]) begin
			chip_select_out    <= cs_q;
			serial_clock_out   <= sk_q;
			serial_data_out    <= di_q;
			serial_data_oe_out <= oe_q;
		end else begin
			chip_select_out    <= 1'h0;
			serial_data_oe_out <= 1'h1;
			serial_data_out    <= gpio_q[eeprom_ctrl_pkg::MON_BIT] ? mii_monitor_in[0] : gpio_q[eeprom_ctrl_pkg::GPO_DAT_BIT];
			serial_clock_out   <= gpio_q[eeprom_ctrl_pkg::MON_BIT] ? mii_monitor_in[1] : gpio_q[eeprom_ctrl_pkg::GPO_CLK_BIT];
		end
	end

	////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	logic [4:0] sk_cnt_q;
	// Counts serial clock rises within one frame
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sk_cnt_q <= 5'h00;
		end else if (state_q == eeprom_ctrl_pkg::ST_START) begin
			sk_cnt_q <= 5'h00;
		end else if (sk_q && !$past(sk_q)) begin
			sk_cnt_q <= sk_cnt_q + 5'h01;
		end
	end

	autoload_busy_a: assert property (reload_q |-> busy_q)
		else $error("reload active without busy");
	busy_end_a: assert property ($fell(busy_q) |-> $past(state_q) == eeprom_ctrl_pkg::ST_FINISH)
		else $error("busy cleared outside finish");
	read_result_a: assert property ($fell(busy_q) && cmd_q == eeprom_ctrl_pkg::CMD_READ && !$past(reload_q)
		&& !$past(abandon_q) |-> data_q == $past(rx_q))
		else $error("read byte not in data register");
	cmd_frozen_a: assert property (busy_q ##1 busy_q |-> $stable(cmd_q) && $stable(addr_q))
		else $error("command changed while busy");
	timeout_flag_a: assert property (tmo_hit && state_q == eeprom_ctrl_pkg::ST_POLL && !soft_reset_in
		|=> to_flag_q ##1 !busy_q)
		else $error("timeout not reported");
	clock_count_a: assert property (state_q == eeprom_ctrl_pkg::ST_SHIFT && bit_end && bits_q == 5'h01
		|=> sk_cnt_q == (is_long(cur_cmd) ? eeprom_ctrl_pkg::LEN_LONG : eeprom_ctrl_pkg::LEN_SHORT))
		else $error("wrong serial clock count");
	gpo_drive_a: assert property (!gpio_q[eeprom_ctrl_pkg::EN_BIT] && !gpio_q[eeprom_ctrl_pkg::MON_BIT]
		&& $stable(gpio_q) |=> serial_clock_out == $past(gpio_q[eeprom_ctrl_pkg::GPO_CLK_BIT])
		&& serial_data_oe_out)
		else $error("disabled pins not driven");
	signature_a: assert property ($rose(loaded_q) |-> reload_q == 1'h0 && $past(idx_q) == eeprom_ctrl_pkg::MAC_LAST
		&& !$past(abandon_q))
		else $error("loaded flag without full reload");
	bad_sig_a: assert property (state_q == eeprom_ctrl_pkg::ST_FINISH && reload_q && !abandon_q && idx_q == 3'h0
		&& rx_q != eeprom_ctrl_pkg::SIGNATURE && !soft_reset_in |=> !reload_q && !busy_q)
		else $error("reload continued without signature");

	write_cov: cover property (host_start && pwdata_in[eeprom_ctrl_pkg::CMD_LSB +: 3] == eeprom_ctrl_pkg::CMD_WRITE);
	poll_cov: cover property (state_q == eeprom_ctrl_pkg::ST_POLL ##1 state_q == eeprom_ctrl_pkg::ST_FINISH);
	load_cov: cover property ($rose(loaded_q));
	tmo_cov: cover property ($rose(to_flag_q));
endmodule

// >>> verification/eeprom_model.sv
// Behavioural three-wire serial EEPROM, 128 x 8, erased value FF.
// Assumes the bench resolves the shared data pin from the controller's enable.
`timescale 1ns/1ps
module eeprom_model (
	// Pins
	input  wire logic       cs_in,
	input  wire logic       sk_in,
	input  wire logic       di_in,
	// Scenario controls: never ready, slow program cycle
	input  wire logic       mute_in,
	input  wire logic       slow_in,
	// Data pin and clocks counted in the last frame
	output logic            do_out,
	output logic [4:0]      clocks_out
);
	logic [7:0]  mem_q [128];
	logic [17:0] sh_q   = 18'h00000;
	logic [9:0]  hd;
	logic [6:0]  ra_q   = 7'h00;
	logic [4:0]  cnt_q  = 5'h00;
	logic        rd_q   = 1'b0;
	logic        drv_q  = 1'b0;
	logic        en_q   = 1'b0; // Powers up write-protected
	logic        pend_q = 1'b0;
	//////////////////////////////////////////////////////////////////////
	// Preload: signature, MAC bytes 11..66, marker at the top location
	initial begin
		clocks_out = 5'h00;
		for (int i = 0; i < 128; i++) begin
			mem_q[i] = (i == 0) ? 8'hA5 : (i < 7) ? 8'(i) * 8'h11 : 8'hFF;
		end
		mem_q[127] = 8'h5A;
	end
	// Ready status while selected and idle, else the read shifter
	assign do_out = (cs_in && cnt_q == 5'h00) ? !(pend_q || mute_in) : drv_q;
	// Shift in header and data; read data follows a dummy zero
	always @(posedge sk_in) if (cs_in) begin
		cnt_q = cnt_q + 5'h01;
		sh_q = {sh_q[16:0], di_in};
		if (cnt_q == 5'h0A) begin
			rd_q = (sh_q[9:7] == 3'h6);
			ra_q = sh_q[6:0];
		end
		if (rd_q) drv_q = (cnt_q > 5'h0A) ? mem_q[ra_q][5'h12 - cnt_q] : 1'b0;
	end
	// Frame end: decode and execute, count kept for the bench
	always @(negedge cs_in) begin
		if (cnt_q != 5'h00) clocks_out = cnt_q; // Status polls carry no clocks
		drv_q = ~do_out;
		hd = (cnt_q == 5'h12) ? sh_q[17:8] : sh_q[9:0];
		if (!(hd[9] && (cnt_q == 5'h0A || cnt_q == 5'h12))) hd = 10'h000;
		if (hd[9:5] == 5'h13) en_q = 1'b1;
		else if (hd[9:5] == 5'h10) en_q = 1'b0;
		else if (hd[9] && en_q && hd[8:7] != 2'h2) begin
			pend_q = 1'b1;
			for (int i = 0; i < 128; i++) begin
				if (hd[8:7] == 2'h0 || i == hd[6:0])
					mem_q[i] = (hd[8:7] == 2'h3 || hd[8:5] == 4'h2) ? 8'hFF : sh_q[7:0];
			end
		end
		cnt_q = 5'h00;
		rd_q = 1'b0;
	end
	// Program cycle, prompt or slow
	always @(posedge pend_q) begin
		#(slow_in ? 20000 : 2000);
		pend_q = 1'b0;
	end
endmodule

// >>> verification/eeprom_ctrl_tb.sv
// Self-checking bench for the serial EEPROM host controller.
// Assumes the package, the controller and the EEPROM model are compiled first.
`timescale 1ns/1ps
module eeprom_ctrl_tb;
	localparam int         TO_CYC = 2000;
	localparam logic [7:0] CMD    = eeprom_ctrl_pkg::CMD_OFS;
	localparam logic [7:0] DAT    = eeprom_ctrl_pkg::DATA_OFS;
	localparam logic [7:0] CFG    = eeprom_ctrl_pkg::GPIO_OFS;
	localparam int         BSY    = eeprom_ctrl_pkg::BUSY_BIT;
	localparam int         TOB    = eeprom_ctrl_pkg::TO_BIT;
	localparam int         LDB    = eeprom_ctrl_pkg::LOADED_BIT;
	logic        core_clk_in   = 1'b0;
	logic        rst_n_in      = 1'b0;
	logic        soft_reset_in = 1'b0;
	logic        psel_in       = 1'b0;
	logic        penable_in    = 1'b0;
	logic        pwrite_in     = 1'b0;
	logic [7:0]  paddr_in      = 8'h00;
	logic [31:0] pwdata_in     = 32'h0;
	logic [1:0]  mii_monitor_in = 2'h0;
	logic        mute          = 1'b0;
	logic        slow          = 1'b0;
	logic [31:0] prdata_out;
	logic [47:0] mac_addr_out;
	logic [4:0]  clocks;
	logic        pready_out, pslverr_out, chip_select_out, serial_clock_out;
	logic        serial_data_out, serial_data_oe_out, ee_do, err;
	wire         serial_data_in = serial_data_oe_out ? serial_data_out : ee_do;
	int          n_errors = 0;
	int          checks = 0;
	int          cyc = 0;
	//////////////////////////////////////////////////////////////////////
	// Design and EEPROM
	eeprom_ctrl #(.TIMEOUT_CYCLES(TO_CYC)) i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.soft_reset_in(soft_reset_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .chip_select_out(chip_select_out), .serial_clock_out(serial_clock_out),
		.serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out),
		.serial_data_in(serial_data_in), .mii_monitor_in(mii_monitor_in), .mac_addr_out(mac_addr_out));
	eeprom_model i_eeprom (.cs_in(chip_select_out), .sk_in(serial_clock_out), .di_in(serial_data_in),
		.mute_in(mute), .slow_in(slow), .do_out(ee_do), .clocks_out(clocks));
	// Clock and hang guard
	initial forever #12.5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			end_sim();
		end
	end
	//////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask
	// One APB transfer; waits for pready without assuming its delay
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 40);
		r = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		check("pready", 32'h1, 32'(pready_out));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(a, 1'b1, d, r);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(a, 1'b0, 32'h0, r);
		check(nm, exp, r);
	endtask
	// Poll busy until it clears
	task automatic wait_idle();
		logic [31:0] r;
		int n;
		n = 0;
		do begin
			apb(CMD, 1'b0, 32'h0, r);
			n++;
		end while (r[BSY] !== 1'b0 && n < 1000);
		check("busy", 32'h0, 32'(r[BSY]));
	endtask
	// Start a command, wait for it, check the frame length if given
	task automatic cmd(input eeprom_ctrl_pkg::cmd_e c, input logic [6:0] a, input logic [4:0] len);
		logic [31:0] v;
		v = 32'h0;
		v[BSY] = 1'b1;
		v[eeprom_ctrl_pkg::CMD_LSB +: 3] = c;
		v[eeprom_ctrl_pkg::ADDR_LSB +: 7] = a;
		wr(CMD, v);
		wait_idle();
		if (len != 5'h00) check("clocks", 32'(len), 32'(clocks));
	endtask
	task automatic mem(input logic [6:0] a, input logic [7:0] e);
		check("eeprom", 32'(e), 32'(i_eeprom.mem_q[a]));
	endtask
	//////////////////////////////////////////////////////////////////////
	// Enable during auto-load is refused; MAC and flags after the load
	task automatic t_boot();
		cmd(eeprom_ctrl_pkg::CMD_UNLOCK, 7'h00, 5'h00);
		rdc("cfg", CFG, 32'h1);
		rdc("maclo", eeprom_ctrl_pkg::MACLO_OFS, 32'h44332211);
		rdc("machi", eeprom_ctrl_pkg::MACHI_OFS, 32'h00006655);
		rdc("loaded", CMD, 32'h1 << LDB);
		rdc("unmapped", 8'h40, 32'h0);
		check("slverr", 32'h1, 32'(err));
	endtask
	// Protected write, enable, slow write, read-back, erase
	task automatic t_rw();
		cmd(eeprom_ctrl_pkg::CMD_READ, 7'h7F, 5'h12);
		rdc("data", DAT, 32'h5A);
		wr(DAT, 32'h3C);
		cmd(eeprom_ctrl_pkg::CMD_WRITE, 7'h10, 5'h12);
		mem(7'h10, 8'hFF);
		cmd(eeprom_ctrl_pkg::CMD_UNLOCK, 7'h00, 5'h0A);
		slow = 1'b1;
		wr(DAT, 32'hC3);
		cmd(eeprom_ctrl_pkg::CMD_WRITE, 7'h10, 5'h12);
		slow = 1'b0;
		mem(7'h10, 8'hC3);
		cmd(eeprom_ctrl_pkg::CMD_READ, 7'h10, 5'h12);
		rdc("data", DAT, 32'hC3);
		cmd(eeprom_ctrl_pkg::CMD_ERASE, 7'h10, 5'h0A);
		mem(7'h10, 8'hFF);
	endtask
	// Bulk commands, failed reload, then reprogram and reload
	task automatic t_bulk();
		wr(DAT, 32'h77);
		cmd(eeprom_ctrl_pkg::CMD_FILL, 7'h00, 5'h12);
		mem(7'h7F, 8'h77);
		cmd(eeprom_ctrl_pkg::CMD_WIPE, 7'h00, 5'h0A);
		mem(7'h00, 8'hFF);
		cmd(eeprom_ctrl_pkg::CMD_RELOAD, 7'h00, 5'h00);
		rdc("loaded", CMD, 32'h70000000);
		for (int i = 0; i < 7; i++) begin
			wr(DAT, (i == 0) ? 32'hA5 : 32'h90 + 32'(i));
			cmd(eeprom_ctrl_pkg::CMD_WRITE, 7'(i), 5'h12);
		end
		cmd(eeprom_ctrl_pkg::CMD_RELOAD, 7'h00, 5'h00);
		rdc("maclo", eeprom_ctrl_pkg::MACLO_OFS, 32'h94939291);
		rdc("loaded", CMD, 32'h70000000 | (32'h1 << LDB));
		check("macport", 32'h00009695, 32'(mac_addr_out[47:32]));
	endtask
	// Write-disable, then a silent EEPROM and the timeout
	task automatic t_tmo();
		int t0;
		cmd(eeprom_ctrl_pkg::CMD_LOCK, 7'h00, 5'h0A);
		wr(DAT, 32'h12);
		cmd(eeprom_ctrl_pkg::CMD_WRITE, 7'h20, 5'h12);
		mem(7'h20, 8'hFF);
		cmd(eeprom_ctrl_pkg::CMD_UNLOCK, 7'h00, 5'h0A);
		mute = 1'b1;
		t0 = cyc;
		cmd(eeprom_ctrl_pkg::CMD_WRITE, 7'h20, 5'h12);
		check("tmo_time", 32'h1, 32'(cyc - t0 >= TO_CYC && cyc - t0 < TO_CYC + 400));
		rdc("tmo_flag", CMD, 32'h30000020 | (32'h1 << TOB) | (32'h1 << LDB));
		mute = 1'b0;
		wr(CMD, 32'h1 << TOB);
		rdc("tmo_clear", CMD, 32'h30000020 | (32'h1 << LDB));
	endtask
	// Disabled interface: pins as outputs and as monitors
	task automatic t_pins();
		wr(CFG, 32'h2);
		repeat (3) @(posedge core_clk_in);
		check("gpo", 32'h3, 32'({chip_select_out, serial_clock_out, serial_data_out, serial_data_oe_out}));
		mii_monitor_in <= 2'h2;
		wr(CFG, 32'h8);
		repeat (3) @(posedge core_clk_in);
		check("mon", 32'h5, 32'({chip_select_out, serial_clock_out, serial_data_out, serial_data_oe_out}));
		wr(CFG, 32'h1);
		@(posedge core_clk_in);
		soft_reset_in <= 1'b1;
		@(posedge core_clk_in);
		soft_reset_in <= 1'b0;
		wait_idle();
		rdc("machi", eeprom_ctrl_pkg::MACHI_OFS, 32'h00009695);
	endtask
	//////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		t_boot();
		t_rw();
		t_bulk();
		t_tmo();
		t_pins();
		end_sim();
	end
endmodule
